// >>> common/cif_pkg.sv
`default_nettype none

package cif_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] CIF_ADDR_INT_ENABLE  = 8'h2B;
  localparam logic [7:0] CIF_ADDR_INT_PENDING = 8'h2C;
  localparam logic [7:0] CIF_ENABLE_RESET     = 8'h00;
  localparam logic [7:0] CIF_PENDING_RESET    = 8'h00;
  localparam logic [7:0] CIF_RDATA_RESET      = 8'h00;
  localparam logic [7:0] CIF_UNMAPPED_RDATA   = 8'h00;
  localparam logic [7:0] CIF_FULL_MASK        = 8'hFF;

  // ==========================================================================
  // Source bit positions, shared by enable and pending registers
  localparam int CIF_BIT_MSG_ERROR   = 7;
  localparam int CIF_BIT_WAKEUP      = 6;
  localparam int CIF_BIT_ERROR_STATE = 5;
  localparam int CIF_BIT_XMIT_BUF2   = 4;
  localparam int CIF_BIT_XMIT_BUF1   = 3;
  localparam int CIF_BIT_XMIT_BUF0   = 2;
  localparam int CIF_BIT_RECV_BUF1   = 1;
  localparam int CIF_BIT_RECV_BUF0   = 0;
  localparam int CIF_NUM_SOURCES     = 8;

  // ==========================================================================
  // Pending priority codes, lower code wins
  localparam logic [2:0] CIF_CODE_NONE      = 3'h0;
  localparam logic [2:0] CIF_CODE_ERROR     = 3'h1;
  localparam logic [2:0] CIF_CODE_WAKEUP    = 3'h2;
  localparam logic [2:0] CIF_CODE_XMIT_BUF0 = 3'h3;
  localparam logic [2:0] CIF_CODE_XMIT_BUF1 = 3'h4;
  localparam logic [2:0] CIF_CODE_XMIT_BUF2 = 3'h5;
  localparam logic [2:0] CIF_CODE_RECV_BUF0 = 3'h6;
  localparam logic [2:0] CIF_CODE_RECV_BUF1 = 3'h7;

  // ==========================================================================
  // Reset values of miscellaneous state
  localparam logic       CIF_BUS_IDLE_LEVEL = 1'b1;
  localparam logic [7:0] CIF_ERROR_COND_RESET = 8'h00;
  localparam logic       CIF_IRQ_N_RESET    = 1'b1;

endpackage : cif_pkg

`default_nettype wire

// >>> core/cif_priority_code.sv
`timescale 1ns/100ps
`default_nettype none

module cif_priority_code
  import cif_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  // Enabled pending sources
  input  wire logic [7:0] active_in,
  // Code of highest-priority source
  output var  logic [2:0] code_out
);

  logic [2:0] code_nxt;

  // ==========================================================================
  // Fixed-priority encoder; message error has no code of its own
  always_comb begin
    if (active_in[CIF_BIT_ERROR_STATE]) begin
      code_nxt = CIF_CODE_ERROR;
    end else if (active_in[CIF_BIT_WAKEUP]) begin
      code_nxt = CIF_CODE_WAKEUP;
    end else if (active_in[CIF_BIT_XMIT_BUF0]) begin
      code_nxt = CIF_CODE_XMIT_BUF0;
    end else if (active_in[CIF_BIT_XMIT_BUF1]) begin
      code_nxt = CIF_CODE_XMIT_BUF1;
    end else if (active_in[CIF_BIT_XMIT_BUF2]) begin
      code_nxt = CIF_CODE_XMIT_BUF2;
    end else if (active_in[CIF_BIT_RECV_BUF0]) begin
      code_nxt = CIF_CODE_RECV_BUF0;
    end else if (active_in[CIF_BIT_RECV_BUF1]) begin
      code_nxt = CIF_CODE_RECV_BUF1;
    end else begin
      code_nxt = CIF_CODE_NONE;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      code_out <= CIF_CODE_NONE;
    end else if (ce_in) begin
      code_out <= code_nxt;
    end
  end

endmodule : cif_priority_code

`default_nettype wire

// >>> core/cif_irq_flags.sv
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Message error flag interrupts when enabled
// - Bus activity interrupts when wakeup enabled
// - Error-condition change interrupts when enabled
// - Enable bits 4..2 arm transmit-empty interrupts
// - Enable bits 1..0 arm receive-full interrupts
// - Enable at 2Bh, pending at 2Ch, same order
// - Pending flag stays set until host clears
// - Both registers read/write, reset to zero
// - Interrupt pin low while enabled flag pending
// - Clear blocked while source condition holds
// - Host writing one sets flag like event
// - Three-bit code of highest enabled source, message error excluded

module cif_irq_flags
  import cif_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ce_in,
  // Register port
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic [7:0] reg_wmask_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_rd_in,
  output var  logic [7:0] reg_rdata_out,
  // Protocol engine events and conditions
  input  wire logic       msg_error_evt_in,
  input  wire logic [2:0] xmit_buf_empty_evt_in,
  input  wire logic [1:0] recv_buf_full_evt_in,
  input  wire logic [7:0] error_condition_in,
  input  wire logic [7:0] source_cond_active_in,
  // Bus receive pin
  input  wire logic       can_rx_pin_in,
  // Interrupt outputs
  output var  logic       irq_n_out,
  output var  logic [2:0] pending_priority_code_out,
  output var  logic [7:0] interrupt_enable_out,
  output var  logic [7:0] interrupt_pending_out
);

  // ==========================================================================
  // Declarations
  logic [7:0] interrupt_enable_reg_r;
  logic [7:0] interrupt_enable_reg_nxt;
  logic [7:0] interrupt_pending_reg_r;
  logic [7:0] interrupt_pending_reg_nxt;
  logic [7:0] error_condition_r;
  logic [7:0] hw_set;
  logic [7:0] host_set;
  logic [7:0] host_clr;
  logic [7:0] active;
  logic       rx_sync1_r;
  logic       rx_sync2_r;
  logic       rx_sync3_r;
  logic       rx_stable_r;
  logic       bus_activity;
  logic       error_cond_change;
  logic       wr_enable;
  logic       wr_pending;

  assign wr_enable  = reg_wr_in && (reg_addr_in == CIF_ADDR_INT_ENABLE);
  assign wr_pending = reg_wr_in && (reg_addr_in == CIF_ADDR_INT_PENDING);

  // ==========================================================================
  // Bus pin synchroniser; first stage feeds only the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_sync1_r <= CIF_BUS_IDLE_LEVEL;
      rx_sync2_r <= CIF_BUS_IDLE_LEVEL;
      rx_sync3_r <= CIF_BUS_IDLE_LEVEL;
    end else if (ce_in) begin
      rx_sync1_r <= can_rx_pin_in;
      rx_sync2_r <= rx_sync1_r;
      rx_sync3_r <= rx_sync2_r;
    end
  end

  // Level only accepted once two stages agree, so one-cycle glitches are dropped
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rx_stable_r <= CIF_BUS_IDLE_LEVEL;
    end else if (ce_in && (rx_sync2_r == rx_sync3_r)) begin
      rx_stable_r <= rx_sync3_r;
    end
  end

  // Dominant edge on an idle bus is bus activity
  assign bus_activity = rx_stable_r && (rx_sync2_r == rx_sync3_r) && !rx_sync3_r;

  // ==========================================================================
  // Error-condition change detect
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      error_condition_r <= CIF_ERROR_COND_RESET;
    end else if (ce_in) begin
      error_condition_r <= error_condition_in;
    end
  end

  assign error_cond_change = |(error_condition_r ^ error_condition_in);

  // ==========================================================================
  // Hardware set vector
  always_comb begin
    hw_set                      = '0;
    hw_set[CIF_BIT_MSG_ERROR]   = msg_error_evt_in;
    hw_set[CIF_BIT_WAKEUP]      = bus_activity;
    hw_set[CIF_BIT_ERROR_STATE] = error_cond_change;
    hw_set[CIF_BIT_XMIT_BUF2]   = xmit_buf_empty_evt_in[2];
    hw_set[CIF_BIT_XMIT_BUF1]   = xmit_buf_empty_evt_in[1];
    hw_set[CIF_BIT_XMIT_BUF0]   = xmit_buf_empty_evt_in[0];
    hw_set[CIF_BIT_RECV_BUF1]   = recv_buf_full_evt_in[1];
    hw_set[CIF_BIT_RECV_BUF0]   = recv_buf_full_evt_in[0];
  end

  // Masked write: plain write uses a full mask, bit modify a partial one
  assign host_set = wr_pending ? (reg_wmask_in & reg_wdata_in) : '0;
  assign host_clr = wr_pending ? (reg_wmask_in & ~reg_wdata_in) : '0;

  // ==========================================================================
  // Per-source pending flag
  generate
    for (genvar i = 0; i < CIF_NUM_SOURCES; i++) begin : g_flag
      always_comb begin
        if (hw_set[i] || host_set[i]) begin
          interrupt_pending_reg_nxt[i] = 1'b1;
        end else if (host_clr[i] && !source_cond_active_in[i]) begin
          interrupt_pending_reg_nxt[i] = 1'b0;
        end else begin
          interrupt_pending_reg_nxt[i] = interrupt_pending_reg_r[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_pending_reg_r <= CIF_PENDING_RESET;
    end else if (ce_in) begin
      interrupt_pending_reg_r <= interrupt_pending_reg_nxt;
    end
  end

  // ==========================================================================
  // Enable register
  assign interrupt_enable_reg_nxt = wr_enable ? ((interrupt_enable_reg_r & ~reg_wmask_in)
                                                | (reg_wdata_in & reg_wmask_in))
                                              : interrupt_enable_reg_r;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_enable_reg_r <= CIF_ENABLE_RESET;
    end else if (ce_in) begin
      interrupt_enable_reg_r <= interrupt_enable_reg_nxt;
    end
  end

  // ==========================================================================
  // Read path
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= CIF_RDATA_RESET;
    end else if (ce_in && reg_rd_in) begin
      if (reg_addr_in == CIF_ADDR_INT_ENABLE) begin
        reg_rdata_out <= interrupt_enable_reg_r;
      end else if (reg_addr_in == CIF_ADDR_INT_PENDING) begin
        reg_rdata_out <= interrupt_pending_reg_r;
      end else begin
        reg_rdata_out <= CIF_UNMAPPED_RDATA;
      end
    end
  end

  // ==========================================================================
  // Interrupt outputs
  assign active = interrupt_pending_reg_nxt & interrupt_enable_reg_nxt;

  // Built from next state so pin and code agree with the register mirrors
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_n_out <= CIF_IRQ_N_RESET;
    end else if (ce_in) begin
      irq_n_out <= ~|active;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      interrupt_enable_out  <= CIF_ENABLE_RESET;
      interrupt_pending_out <= CIF_PENDING_RESET;
    end else if (ce_in) begin
      interrupt_enable_out  <= interrupt_enable_reg_nxt;
      interrupt_pending_out <= interrupt_pending_reg_nxt;
    end
  end

  cif_priority_code u_code (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .active_in (active),
    .code_out  (pending_priority_code_out)
  );

endmodule : cif_irq_flags

`default_nettype wire

// >>> tb/cif_checker.sv
`timescale 1ns/100ps
`default_nettype none
module cif_checker
  import cif_pkg::*;
(
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       arst_n_in,
  input wire logic       ce_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wmask_in,
  input wire logic [7:0] reg_wdata_in,
  // Sources
  input wire logic       msg_error_evt_in,
  input wire logic [1:0] recv_buf_full_evt_in,
  input wire logic [7:0] error_condition_in,
  input wire logic [7:0] source_cond_active_in,
  input wire logic       can_rx_pin_in,
  // Outputs
  input wire logic       irq_n_out,
  input wire logic [2:0] pending_priority_code_out,
  input wire logic [7:0] interrupt_enable_out,
  input wire logic [7:0] interrupt_pending_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ==========
  // Sequences
  sequence wr_at(logic [7:0] a);
    ce_in && reg_wr_in && reg_addr_in == a;
  endsequence
  // Pin must stay low through the synchroniser and agree check
  sequence pin_fall;
    ce_in && $fell(can_rx_pin_in) ##1 (ce_in && !can_rx_pin_in)[*3];
  endsequence
  // Last error condition the device took; a frozen clock enable must not look like a change
  logic [7:0] err_seen_r;
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      err_seen_r <= CIF_ERROR_COND_RESET;
    end else if (ce_in) begin
      err_seen_r <= error_condition_in;
    end
  end
  // ==========
  // Assertions
  chk_irq_level: assert property (irq_n_out == !(|(interrupt_enable_out & interrupt_pending_out)))
    else $error("irq level wrong");
  chk_code_first: assert property (interrupt_enable_out[5] && interrupt_pending_out[5] |-> pending_priority_code_out == CIF_CODE_ERROR)
    else $error("code not error");
  chk_code_none: assert property ((interrupt_enable_out & interrupt_pending_out & 8'h7F) == 8'h00 |-> pending_priority_code_out == CIF_CODE_NONE)
    else $error("code not none");
  chk_enable_write: assert property (wr_at(CIF_ADDR_INT_ENABLE) |=> interrupt_enable_out == (($past(interrupt_enable_out) & ~$past(reg_wmask_in)) | ($past(reg_wdata_in) & $past(reg_wmask_in))))
    else $error("enable write wrong");
  chk_merr_set: assert property (ce_in && msg_error_evt_in |=> interrupt_pending_out[7])
    else $error("msg error not set");
  chk_recv_set: assert property (ce_in && recv_buf_full_evt_in[1] |=> interrupt_pending_out[1])
    else $error("recv flag not set");
  chk_clear_held: assert property (wr_at(CIF_ADDR_INT_PENDING) ##0 (source_cond_active_in[2] && interrupt_pending_out[2]) |=> interrupt_pending_out[2])
    else $error("held flag cleared");
  chk_flag_sticky: assert property (interrupt_pending_out[3] && !(ce_in && reg_wr_in && reg_addr_in == CIF_ADDR_INT_PENDING) |=> interrupt_pending_out[3])
    else $error("flag dropped");
  chk_err_change: assert property (ce_in && error_condition_in != err_seen_r |=> interrupt_pending_out[5])
    else $error("error change missed");
  chk_wake_pin: assert property (pin_fall |=> interrupt_pending_out[6])
    else $error("wake missed");
endmodule : cif_checker
bind cif_irq_flags cif_checker chk (
  .clk_in                    (clk_in),
  .arst_n_in                 (arst_n_in),
  .ce_in                     (ce_in),
  .reg_addr_in               (reg_addr_in),
  .reg_wr_in                 (reg_wr_in),
  .reg_wmask_in              (reg_wmask_in),
  .reg_wdata_in              (reg_wdata_in),
  .msg_error_evt_in          (msg_error_evt_in),
  .recv_buf_full_evt_in      (recv_buf_full_evt_in),
  .error_condition_in        (error_condition_in),
  .source_cond_active_in     (source_cond_active_in),
  .can_rx_pin_in             (can_rx_pin_in),
  .irq_n_out                 (irq_n_out),
  .pending_priority_code_out (pending_priority_code_out),
  .interrupt_enable_out      (interrupt_enable_out),
  .interrupt_pending_out     (interrupt_pending_out)
);
`default_nettype wire

// >>> tb/cif_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module cif_host_model (
  // Clock and read data
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  // Register requests
  output var  logic [7:0] addr_out,
  output var  logic       wr_out,
  output var  logic [7:0] wmask_out,
  output var  logic [7:0] wdata_out,
  output var  logic       rd_out
);
  initial begin
    {addr_out, wr_out, wmask_out, wdata_out, rd_out} = '0;
  end
  // ==========
  // Accesses; released address and data lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, m, d);
    @(posedge clk_in);
    addr_out <= a;
    wmask_out <= m;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    @(negedge clk_in);
    d = rdata_in;
  endtask : rd
endmodule : cif_host_model
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import cif_pkg::*;
();
  // ==========
  // Signals
  logic       clk_in, arst_n_in, ce_in, rx_pin, msg_evt, wr, rd, irq_n;
  logic [7:0] addr, wmask, wdata, rdata, err_cond, cond_act, en_o, pend_o, rv;
  logic [2:0] xmit_evt, code;
  logic [1:0] recv_evt;
  int         err_total, check_count, exp_en, exp_pend, i, b;
  integer     seed;
  int         pri[8] = '{5, 6, 2, 3, 4, 0, 1, 7};
  cif_host_model host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .wmask_out(wmask),
                       .wdata_out(wdata), .rd_out(rd));
  cif_irq_flags uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .reg_addr_in(addr), .reg_wr_in(wr),
    .reg_wmask_in(wmask), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata), .msg_error_evt_in(msg_evt),
    .xmit_buf_empty_evt_in(xmit_evt), .recv_buf_full_evt_in(recv_evt), .error_condition_in(err_cond),
    .source_cond_active_in(cond_act), .can_rx_pin_in(rx_pin), .irq_n_out(irq_n), .pending_priority_code_out(code),
    .interrupt_enable_out(en_o), .interrupt_pending_out(pend_o));
  // ==========
  // Model and comparisons
  function automatic logic [2:0] exp_code(int a);
    for (int k = 0; k < 7; k++) begin
      if (a[pri[k]]) return 3'(k + 1);
    end
    return CIF_CODE_NONE;
  endfunction : exp_code
  task automatic cmp(logic [7:0] got, int exp);
    check_count++;
    if (got !== 8'(exp)) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, got, 8'(exp));
    end
  endtask : cmp
  task automatic cmp_irq();
    cmp({4'h0, irq_n, code}, {4'h0, ~|(exp_en & exp_pend & 8'hFF), exp_code(exp_en & exp_pend)});
  endtask : cmp_irq
  // Clears on held sources are dropped by the device, not deferred
  task automatic wr_reg(logic [7:0] a, logic [7:0] m, logic [7:0] d);
    host.wr(a, m, d);
    if (a == CIF_ADDR_INT_ENABLE) exp_en = (exp_en & ~m) | (d & m);
    if (a == CIF_ADDR_INT_PENDING) exp_pend = (exp_pend & ~(m & ~cond_act)) | (d & m);
    @(negedge clk_in);
  endtask : wr_reg
  task automatic rd_chk(logic [7:0] a, int exp);
    logic [7:0] v;
    host.rd(a, v);
    cmp(v, exp);
  endtask : rd_chk
  task automatic pulse(logic m, logic [2:0] t, logic [1:0] r);
    @(posedge clk_in);
    {msg_evt, xmit_evt, recv_evt} <= {m, t, r};
    @(posedge clk_in);
    {msg_evt, xmit_evt, recv_evt} <= 6'h00;
    @(negedge clk_in);
    exp_pend |= {m, 2'b00, t, r};
  endtask : pulse
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  // ==========
  // Clock, watchdog, sequence
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end
  initial begin
    arst_n_in   = 1'b0;
    ce_in       = 1'b1;
    rx_pin      = CIF_BUS_IDLE_LEVEL;
    {msg_evt, xmit_evt, recv_evt} = 6'h00;
    err_cond    = 8'h00;
    cond_act    = 8'h00;
    err_total   = 0;
    check_count = 0;
    exp_en      = 0;
    exp_pend    = 0;
    seed        = 32'hC335;
    repeat (3) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(negedge clk_in);
    cmp_irq();
    rd_chk(CIF_ADDR_INT_PENDING, CIF_PENDING_RESET);
    wr_reg(CIF_ADDR_INT_ENABLE, 8'hFF, 8'hFF);
    rd_chk(CIF_ADDR_INT_ENABLE, exp_en);
    wr_reg(CIF_ADDR_INT_PENDING, 8'hFF, 8'hFF);
    rd_chk(CIF_ADDR_INT_PENDING, exp_pend);
    for (i = 0; i < 8; i++) begin
      wr_reg(CIF_ADDR_INT_PENDING, 8'h01 << pri[i], 8'h00);
      cmp(pend_o, exp_pend);
      cmp_irq();
    end
    for (i = 0; i < 6; i++) begin
      b = 1 << i;
      pulse(b[5], b[4:2], b[1:0]);
      cmp(pend_o, exp_pend);
    end
    fork
      wr_reg(CIF_ADDR_INT_PENDING, 8'h80, 8'h00);
      pulse(1'b1, 3'h0, 2'h0);
    join
    cmp(pend_o, exp_pend);
    @(posedge clk_in);
    cond_act <= 8'h04;
    wr_reg(CIF_ADDR_INT_PENDING, 8'h04, 8'h00);
    cmp(pend_o, exp_pend);
    @(posedge clk_in);
    cond_act <= 8'h00;
    wr_reg(CIF_ADDR_INT_PENDING, 8'h04, 8'h00);
    cmp(pend_o, exp_pend);
    @(posedge clk_in);
    err_cond <= 8'h10;
    repeat (2) @(negedge clk_in);
    exp_pend |= 8'h20;
    cmp(pend_o, exp_pend);
    wr_reg(CIF_ADDR_INT_PENDING, 8'h20, 8'h00);
    cmp(pend_o, exp_pend);
    @(posedge clk_in);
    rx_pin <= 1'b0;
    repeat (5) @(negedge clk_in);
    exp_pend |= 8'h40;
    cmp(pend_o, exp_pend);
    @(posedge clk_in);
    rx_pin <= 1'b1;
    for (i = 0; i < 8; i++) begin
      rv = 8'($random(seed));
      wr_reg(CIF_ADDR_INT_ENABLE, 8'hFF, rv);
      cmp_irq();
      rv = 8'($random(seed));
      wr_reg(CIF_ADDR_INT_PENDING, 8'hFF, rv);
      cmp_irq();
    end
    wr_reg(8'h2D, 8'hFF, 8'hFF);
    cmp(en_o, exp_en);
    rd_chk(8'h2D, CIF_UNMAPPED_RDATA);
    // Clock enable low must swallow an event pulse
    wr_reg(CIF_ADDR_INT_PENDING, 8'hFF, 8'h00);
    @(posedge clk_in);
    ce_in <= 1'b0;
    msg_evt <= 1'b1;
    repeat (3) @(posedge clk_in);
    ce_in <= 1'b1;
    msg_evt <= 1'b0;
    @(negedge clk_in);
    cmp(pend_o, exp_pend);
    cmp_irq();
    // Mid-run reset returns both registers to zero
    wr_reg(CIF_ADDR_INT_PENDING, 8'hFF, 8'hFF);
    @(posedge clk_in);
    arst_n_in <= 1'b0;
    err_cond <= 8'h00;
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    exp_en = 0;
    exp_pend = 0;
    @(negedge clk_in);
    cmp(en_o, exp_en);
    cmp(pend_o, exp_pend);
    cmp_irq();
    rd_chk(CIF_ADDR_INT_PENDING, CIF_PENDING_RESET);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
